// *** include/stca_pkg.sv ***
package stca_pkg;

    // Register indices; the bus byte address is four times the index
    localparam logic [5:0] IDX_TX_DATA   = 6'h02;
    localparam logic [5:0] IDX_TX_CTL    = 6'h03;
    localparam logic [5:0] IDX_THRESH    = 6'h04;
    localparam logic [5:0] IDX_CTL_FIRST = 6'h06;
    localparam logic [5:0] IDX_CTL_SEC   = 6'h07;
    localparam logic [5:0] IDX_STATUS    = 6'h24;
    localparam logic [5:0] IDX_RX_POWER  = 6'h2d;

    // control_first fields
    localparam int SEQ_LSB       = 0;
    localparam int TYPE_LSB      = 4;
    localparam int TMR_TRIG_BIT  = 7;
    localparam int WORD_MASK_BIT = 9;
    localparam int MEAS_MASK_BIT = 10;
    localparam int TX_STRM_BIT   = 12;
    // control_second fields
    localparam int USE_STRM_BIT  = 5;
    localparam int DONE_MASK_BIT = 7;
    localparam int ERR_MASK_BIT  = 8;
    // interrupt_status fields
    localparam int BUSY_BIT      = 1;
    localparam int ERR_BIT       = 2;
    localparam int MEAS_BIT      = 5;
    localparam int WORD_BIT      = 6;
    localparam int DONE_BIT      = 14;

    localparam logic [1:0] SEQ_STREAM    = 2'h0;
    localparam logic [1:0] SEQ_ASSESS    = 2'h1;
    localparam logic [1:0] TYPE_THRESH   = 2'h1;
    localparam logic [1:0] TYPE_ENERGY   = 2'h2;

    localparam logic [7:0]  COMP_RESET   = 8'h8d;
    localparam logic [7:0]  THRESH_RESET = 8'h00;
    localparam logic [6:0]  FCS_BYTES    = 7'h02;
    localparam logic [7:0]  PREAMBLE     = 8'h00;
    localparam logic [7:0]  START_DELIM  = 8'ha7;
    localparam logic [6:0]  SHR_LAST     = 7'h04;
    localparam logic [15:0] FCS_POLY     = 16'h8408;

    // Timing
    localparam int CLK_MHZ      = 250;
    localparam int WARM_US      = 144;
    localparam int AVG_US       = 128;
    localparam int AVG_SYMBOLS  = 8;
    localparam int WORD_US      = 64;
    localparam int WARM_CYCLES  = WARM_US * CLK_MHZ;
    localparam int SYM_CYCLES   = AVG_US * CLK_MHZ / AVG_SYMBOLS;
    localparam int BYTE_CYCLES  = WORD_US * CLK_MHZ / 2;

    typedef enum logic [2:0] {ST_IDLE, ST_SHR, ST_LEN, ST_PAY, ST_FCS, ST_MEAS} stca_state_t;
    typedef enum logic [1:0] {MS_IDLE, MS_WARM, MS_AVG} stca_meas_t;

endpackage : stca_pkg

// *** logic/stca_fcs_gen.sv ***
`timescale 1ns/100ps
module stca_fcs_gen
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_in,
    output logic      [15:0] crc
);

    // Reflected CCITT polynomial, zero start value, low bit first on air
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ b[i])
                r = (r >> 1) ^ stca_pkg::FCS_POLY;
            else
                r = r >> 1;
        end
        return r;
    endfunction : crc_step

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            crc <= 16'h0000;
        else if (clear)
            crc <= 16'h0000;
        else if (byte_valid)
            crc <= crc_step(crc, byte_in);
    end

endmodule : stca_fcs_gen

// *** logic/stca_power_meas.sv ***
`timescale 1ns/100ps
module stca_power_meas
#(
    parameter int WARM = stca_pkg::WARM_CYCLES,
    parameter int SYM  = stca_pkg::SYM_CYCLES
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [7:0] level,
    input  wire logic [7:0] comp,
    output logic            done,
    output logic      [7:0] result
);

    stca_pkg::stca_meas_t state_r;
    logic [16:0] cnt_r;
    logic [2:0]  sym_r;
    logic [10:0] acc_r;
    logic [10:0] acc_nxt;
    logic [8:0]  sum;

    assign acc_nxt = acc_r + {3'h0, level};
    // Mean of eight samples plus half the compensation, saturated
    assign sum = {1'b0, acc_nxt[10:3]} + {2'h0, comp[7:1]};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= stca_pkg::MS_IDLE;
            cnt_r   <= 17'h00000;
            sym_r   <= 3'h0;
            acc_r   <= 11'h000;
            done    <= 1'b0;
            result  <= 8'h00;
        end
        else
        begin
            done <= 1'b0;
            if (abort)
                state_r <= stca_pkg::MS_IDLE;
            else
            begin
                unique case (state_r)
                    stca_pkg::MS_IDLE:
                        if (start)
                        begin
                            state_r <= stca_pkg::MS_WARM;
                            cnt_r   <= 17'(WARM - 1);
                        end
                    stca_pkg::MS_WARM:
                        if (cnt_r == 17'h00000)
                        begin
                            state_r <= stca_pkg::MS_AVG;
                            cnt_r   <= 17'(SYM - 1);
                            sym_r   <= 3'h0;
                            acc_r   <= 11'h000;
                        end
                        else
                            cnt_r <= cnt_r - 17'h00001;
                    stca_pkg::MS_AVG:
                        if (cnt_r != 17'h00000)
                            cnt_r <= cnt_r - 17'h00001;
                        else
                        begin
                            // One sample at the end of each symbol period
                            acc_r <= acc_nxt;
                            sym_r <= sym_r + 3'h1;
                            cnt_r <= 17'(SYM - 1);
                            if (sym_r == 3'h7)
                            begin
                                state_r <= stca_pkg::MS_IDLE;
                                done    <= 1'b1;
                                result  <= sum[8] ? 8'hff : sum[7:0];
                            end
                        end
                endcase
            end
        end
    end

endmodule : stca_power_meas

// *** logic/stca_modem.sv ***
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module stca_modem
#(
    parameter int WARM_CYC = stca_pkg::WARM_CYCLES,
    parameter int SYM_CYC  = stca_pkg::SYM_CYCLES,
    parameter int BYTE_CYC = stca_pkg::BYTE_CYCLES
)
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        SEQUENCE_ENABLE_PIN,
    input  wire logic [7:0]  RSSI_LEVEL,
    output logic             IRQ,
    output logic      [7:0]  TX_BYTE,
    output logic             TX_BYTE_VALID,
    output logic             OUT_OF_IDLE_INDICATOR
);

    logic        rst_meta_r;
    logic        rst_n_i;
    logic        wr_pend_r;
    logic [5:0]  wr_idx_r;
    logic        addr_ok;
    logic        rd_status;
    logic [15:0] ctl_a_r;
    logic [15:0] ctl_b_r;
    logic [6:0]  tx_len_r;
    logic [7:0]  thresh_r;
    logic [7:0]  comp_r;
    logic [7:0]  power_r;
    logic        busy_r;
    logic [3:0]  evt_r;
    logic [3:0]  evt_set;
    logic [3:0]  evt_clr;
    logic [3:0]  evt_mask;
    logic [15:0] hold_r;
    logic        hold_full_r;
    logic        data_wr;
    logic        spent_r;
    stca_pkg::stca_state_t state_r;
    logic [6:0]  byte_cnt_r;
    logic [15:0] byte_tmr_r;
    logic [15:0] word_r;
    logic        tick;
    logic [6:0]  pay_len;
    logic        load_word;
    logic        more_words;
    logic        last_pay;
    logic [7:0]  byte_nxt;
    logic        emit;
    logic        tx_go;
    logic        meas_go;
    logic        abort;
    logic        meas_done;
    logic [7:0]  meas_result;
    logic [15:0] crc;

    // Event bit order inside evt_r
    localparam int EV_WORD = 0;
    localparam int EV_DONE = 1;
    localparam int EV_MEAS = 2;
    localparam int EV_ERR  = 3;

    function automatic logic hit(input logic [5:0] idx, input logic [5:0] reg_idx);
        return idx == reg_idx;
    endfunction : hit

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta_r <= 1'b0;
            rst_n_i    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_i    <= rst_meta_r;
        end
    end

    // Bus slave: zero wait states, always OKAY, word accesses only
    assign addr_ok   = HSEL && HREADY && HTRANS[1] && (HSIZE == 3'h2);
    assign rd_status = addr_ok && !HWRITE && hit(HADDR[7:2], stca_pkg::IDX_STATUS);
    assign data_wr   = wr_pend_r && hit(wr_idx_r, stca_pkg::IDX_TX_DATA);

    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 6'h00;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            if (HREADY)
            begin
                wr_pend_r <= addr_ok && HWRITE;
                wr_idx_r  <= HADDR[7:2];
            end
        end
    end

    // Read data is sampled in the address phase, so a read right after a write sees the old value
    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
            HRDATA <= 32'h00000000;
        else if (addr_ok && !HWRITE)
        begin
            HRDATA <= 32'h00000000;
            unique case (1'b1)
                hit(HADDR[7:2], stca_pkg::IDX_TX_CTL):    HRDATA[6:0]  <= tx_len_r;
                hit(HADDR[7:2], stca_pkg::IDX_THRESH):    HRDATA[15:0] <= {thresh_r, comp_r};
                hit(HADDR[7:2], stca_pkg::IDX_CTL_FIRST): HRDATA[15:0] <= ctl_a_r;
                hit(HADDR[7:2], stca_pkg::IDX_CTL_SEC):   HRDATA[15:0] <= ctl_b_r;
                hit(HADDR[7:2], stca_pkg::IDX_STATUS):
                begin
                    HRDATA[stca_pkg::DONE_BIT] <= evt_r[EV_DONE];
                    HRDATA[stca_pkg::WORD_BIT] <= evt_r[EV_WORD];
                    HRDATA[stca_pkg::MEAS_BIT] <= evt_r[EV_MEAS];
                    HRDATA[stca_pkg::ERR_BIT]  <= evt_r[EV_ERR];
                    HRDATA[stca_pkg::BUSY_BIT] <= busy_r;
                end
                hit(HADDR[7:2], stca_pkg::IDX_RX_POWER):  HRDATA[15:8] <= power_r;
                default:                                  HRDATA       <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctl_a_r  <= 16'h0000;
            ctl_b_r  <= 16'h0000;
            tx_len_r <= 7'h00;
            thresh_r <= stca_pkg::THRESH_RESET;
            comp_r   <= stca_pkg::COMP_RESET;
        end
        else if (wr_pend_r)
        begin
            if (hit(wr_idx_r, stca_pkg::IDX_CTL_FIRST))
                ctl_a_r <= HWDATA[15:0];
            if (hit(wr_idx_r, stca_pkg::IDX_CTL_SEC))
                ctl_b_r <= HWDATA[15:0];
            if (hit(wr_idx_r, stca_pkg::IDX_TX_CTL))
                tx_len_r <= HWDATA[6:0];
            if (hit(wr_idx_r, stca_pkg::IDX_THRESH))
            begin
                thresh_r <= HWDATA[15:8];
                comp_r   <= HWDATA[7:0];
            end
        end
    end

    // Holding word; a fresh write replaces it
    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hold_r      <= 16'h0000;
            hold_full_r <= 1'b0;
        end
        else if (data_wr)
        begin
            hold_r      <= HWDATA[15:0];
            hold_full_r <= 1'b1;
        end
        else if (load_word)
            hold_full_r <= 1'b0;
    end

    // Sticky events; a set in the same cycle as a clear wins
    assign evt_clr = {4{rd_status}} | {3'h0, data_wr};
    assign evt_mask = {ctl_b_r[stca_pkg::ERR_MASK_BIT], ctl_a_r[stca_pkg::MEAS_MASK_BIT],
                       ctl_b_r[stca_pkg::DONE_MASK_BIT], ctl_a_r[stca_pkg::WORD_MASK_BIT]};

    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            evt_r <= 4'h0;
            IRQ   <= 1'b0;
        end
        else
        begin
            evt_r <= (evt_r & ~evt_clr) | evt_set;
            IRQ   <= |(((evt_r & ~evt_clr) | evt_set) & evt_mask);
        end
    end

    // Launch, with a guard against relaunch
    assign tx_go   = (state_r == stca_pkg::ST_IDLE) && SEQUENCE_ENABLE_PIN && !spent_r
                   && ctl_a_r[stca_pkg::TX_STRM_BIT] && ctl_b_r[stca_pkg::USE_STRM_BIT]
                   && !ctl_a_r[stca_pkg::TMR_TRIG_BIT]
                   && (ctl_a_r[stca_pkg::SEQ_LSB +: 2] == stca_pkg::SEQ_STREAM);
    assign meas_go = (state_r == stca_pkg::ST_IDLE) && SEQUENCE_ENABLE_PIN && !spent_r && !tx_go
                   && (ctl_a_r[stca_pkg::SEQ_LSB +: 2] == stca_pkg::SEQ_ASSESS)
                   && ((ctl_a_r[stca_pkg::TYPE_LSB +: 2] == stca_pkg::TYPE_THRESH)
                       || (ctl_a_r[stca_pkg::TYPE_LSB +: 2] == stca_pkg::TYPE_ENERGY));
    assign abort   = !SEQUENCE_ENABLE_PIN && (state_r != stca_pkg::ST_IDLE);

    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
            spent_r <= 1'b0;
        else if (evt_set[EV_DONE] || meas_done)
            spent_r <= 1'b1;
        else if (!SEQUENCE_ENABLE_PIN
                 || (wr_pend_r && hit(wr_idx_r, stca_pkg::IDX_CTL_FIRST) && HWDATA[stca_pkg::TX_STRM_BIT]))
            spent_r <= 1'b0;
    end

    // Frame sequencing
    assign tick       = (byte_tmr_r == 16'h0000);
    assign pay_len    = (tx_len_r >= stca_pkg::FCS_BYTES) ? tx_len_r - stca_pkg::FCS_BYTES : 7'h00;
    assign last_pay   = (byte_cnt_r + 7'h01) == pay_len;
    assign load_word  = tick && (((state_r == stca_pkg::ST_LEN) && (pay_len != 7'h00))
                        || ((state_r == stca_pkg::ST_PAY) && byte_cnt_r[0] && !last_pay));
    // Request only if bytes remain after the word just taken
    assign more_words = (state_r == stca_pkg::ST_LEN) ? (pay_len > 7'h02)
                      : (({1'b0, byte_cnt_r} + 8'h03) < {1'b0, pay_len});
    assign evt_set[EV_WORD] = load_word && more_words;
    assign evt_set[EV_ERR]  = load_word && !hold_full_r;
    assign evt_set[EV_DONE] = tick && (state_r == stca_pkg::ST_FCS) && byte_cnt_r[0];
    assign evt_set[EV_MEAS] = meas_done;
    assign emit = tick && (state_r != stca_pkg::ST_IDLE) && (state_r != stca_pkg::ST_MEAS);

    always_comb
    begin
        byte_nxt = 8'h00;
        unique case (state_r)
            stca_pkg::ST_SHR: byte_nxt = (byte_cnt_r == stca_pkg::SHR_LAST) ? stca_pkg::START_DELIM
                                                                            : stca_pkg::PREAMBLE;
            stca_pkg::ST_LEN: byte_nxt = {1'b0, tx_len_r};
            stca_pkg::ST_PAY: byte_nxt = byte_cnt_r[0] ? word_r[15:8] : word_r[7:0];
            stca_pkg::ST_FCS: byte_nxt = byte_cnt_r[0] ? crc[15:8] : crc[7:0];
            default:          byte_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r    <= stca_pkg::ST_IDLE;
            byte_cnt_r <= 7'h00;
            byte_tmr_r <= 16'h0000;
            word_r     <= 16'h0000;
        end
        else if (abort)
            state_r <= stca_pkg::ST_IDLE;
        else if (tx_go)
        begin
            state_r    <= stca_pkg::ST_SHR;
            byte_cnt_r <= 7'h00;
            byte_tmr_r <= 16'h0000;
        end
        else if (meas_go)
            state_r <= stca_pkg::ST_MEAS;
        else if (state_r == stca_pkg::ST_MEAS)
        begin
            if (meas_done)
                state_r <= stca_pkg::ST_IDLE;
        end
        else if (state_r != stca_pkg::ST_IDLE)
        begin
            byte_tmr_r <= tick ? 16'(BYTE_CYC - 1) : byte_tmr_r - 16'h0001;
            if (load_word)
                word_r <= hold_full_r ? hold_r : 16'h0000;
            if (tick)
            begin
                byte_cnt_r <= byte_cnt_r + 7'h01;
                unique case (state_r)
                    stca_pkg::ST_SHR:
                        if (byte_cnt_r == stca_pkg::SHR_LAST)
                            state_r <= stca_pkg::ST_LEN;
                    stca_pkg::ST_LEN:
                    begin
                        byte_cnt_r <= 7'h00;
                        state_r    <= (pay_len == 7'h00) ? stca_pkg::ST_FCS : stca_pkg::ST_PAY;
                    end
                    stca_pkg::ST_PAY:
                        if (last_pay)
                        begin
                            byte_cnt_r <= 7'h00;
                            state_r    <= stca_pkg::ST_FCS;
                        end
                    stca_pkg::ST_FCS:
                        if (byte_cnt_r[0])
                            state_r <= stca_pkg::ST_IDLE;
                    default:
                        state_r <= stca_pkg::ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            TX_BYTE               <= 8'h00;
            TX_BYTE_VALID         <= 1'b0;
            OUT_OF_IDLE_INDICATOR <= 1'b0;
        end
        else
        begin
            TX_BYTE_VALID         <= emit && !abort;
            OUT_OF_IDLE_INDICATOR <= (state_r != stca_pkg::ST_IDLE) || tx_go || meas_go;
            if (emit)
                TX_BYTE <= byte_nxt;
        end
    end

    // Busy bit belongs to the threshold algorithm only
    always_ff @(posedge CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            power_r <= 8'h00;
            busy_r  <= 1'b0;
        end
        else if (meas_done)
        begin
            power_r <= meas_result;
            if (ctl_a_r[stca_pkg::TYPE_LSB +: 2] == stca_pkg::TYPE_THRESH)
                busy_r <= (meas_result <= thresh_r);
        end
    end

    stca_power_meas
    #(
        .WARM   (WARM_CYC),
        .SYM    (SYM_CYC)
    )
    u_meas
    (
        .clk    (CLK),
        .rst_n  (rst_n_i),
        .start  (meas_go),
        .abort  (abort),
        .level  (RSSI_LEVEL),
        .comp   (comp_r),
        .done   (meas_done),
        .result (meas_result)
    );

    stca_fcs_gen u_fcs
    (
        .clk        (CLK),
        .rst_n      (rst_n_i),
        .clear      (tx_go),
        .byte_valid (emit && (state_r == stca_pkg::ST_PAY)),
        .byte_in    (byte_nxt),
        .crc        (crc)
    );

endmodule : stca_modem

// *** verification/stca_host.sv ***
`timescale 1ns/100ps
module stca_host
(
    input  logic        clk,
    input  logic        hready,
    input  logic [31:0] hrdata,
    output logic        hsel,
    output logic [7:0]  haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata,
    output logic        seq_en
);
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata, seq_en} = '0;

    task automatic xfer(input logic [5:0] idx, input logic w, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        hsel   <= 1'h1;
        haddr  <= {idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        do @(posedge clk); while (hready !== 1'h1);
        q = hrdata[15:0];
    endtask : xfer

    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        logic [15:0] q;
        xfer(idx, 1'h1, d, q);
    endtask : wr

    // Enable low first: no half-configured start
    task automatic arm_stream(input logic [6:0] len, input logic [15:0] w0, input logic [15:0] c2,
                              input logic [15:0] msk);
        seq_en <= 1'h0;
        wr(stca_pkg::IDX_CTL_SEC, c2 | 16'h0020);
        wr(stca_pkg::IDX_TX_CTL, {9'h000, len});
        wr(stca_pkg::IDX_TX_DATA, w0);
        wr(stca_pkg::IDX_CTL_FIRST, msk | 16'h1000);
        seq_en <= 1'h1;
    endtask : arm_stream

    task automatic arm_assess(input logic [15:0] thc, input logic [1:0] typ);
        seq_en <= 1'h0;
        wr(stca_pkg::IDX_CTL_SEC, 16'h0000);
        wr(stca_pkg::IDX_THRESH, thc);
        wr(stca_pkg::IDX_CTL_FIRST, {10'h010, typ, 4'h1});
        seq_en <= 1'h1;
    endtask : arm_assess
endmodule : stca_host

// *** verification/stca_monitor.sv ***
`timescale 1ns/100ps
module stca_monitor
#(
    parameter int BYTE_CYC = stca_pkg::BYTE_CYCLES
)
(
    input logic        CLK,
    input logic        RST_N,
    input logic        HSEL,
    input logic [1:0]  HTRANS,
    input logic        HWRITE,
    input logic        HREADY,
    input logic [31:0] HRDATA,
    input logic        HREADYOUT,
    input logic        HRESP,
    input logic        SEQUENCE_ENABLE_PIN,
    input logic [7:0]  TX_BYTE,
    input logic        TX_BYTE_VALID,
    input logic        OUT_OF_IDLE_INDICATOR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Cycles since last strobe; zero before a frame
    logic [15:0] gap_r;
    always_ff @(posedge CLK or negedge RST_N)
        if (!RST_N)
            gap_r <= 16'h0000;
        else if (TX_BYTE_VALID)
            gap_r <= 16'h0001;
        else if (!OUT_OF_IDLE_INDICATOR)
            gap_r <= 16'h0000;
        else if (gap_r != 16'h0000)
            gap_r <= gap_r + 16'h0001;

    chk_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus not okay");
    chk_read_upper: assert property (HSEL && HREADY && HTRANS[1] && !HWRITE |=> HRDATA[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_valid_pulse: assert property (TX_BYTE_VALID |=> !TX_BYTE_VALID)
        else $error("strobe too long");
    chk_valid_busy: assert property (TX_BYTE_VALID |-> OUT_OF_IDLE_INDICATOR)
        else $error("byte sent while idle");
    chk_byte_gap: assert property (TX_BYTE_VALID && gap_r != 16'h0000 |-> gap_r == 16'(BYTE_CYC))
        else $error("byte spacing wrong");
    chk_first_byte: assert property (TX_BYTE_VALID && gap_r == 16'h0000 |-> TX_BYTE == 8'h00)
        else $error("no preamble first");
    chk_byte_hold: assert property (!TX_BYTE_VALID |-> $stable(TX_BYTE))
        else $error("byte changed without strobe");
    chk_start_enable: assert property ($rose(OUT_OF_IDLE_INDICATOR) |-> $past(SEQUENCE_ENABLE_PIN))
        else $error("start without enable");
    chk_abort_idle: assert property ($fell(SEQUENCE_ENABLE_PIN) |-> ##[1:3] !OUT_OF_IDLE_INDICATOR)
        else $error("no abort to idle");

    cov_delim: cover property (TX_BYTE_VALID && TX_BYTE == 8'ha7);
    cov_seq_end: cover property ($fell(OUT_OF_IDLE_INDICATOR));
    cov_read: cover property (HSEL && HTRANS[1] && !HWRITE);
endmodule : stca_monitor

bind stca_modem stca_monitor #(.BYTE_CYC(BYTE_CYC)) i_stca_monitor (.*);

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    localparam int WC = 20;
    localparam int SC = 4;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        hsel, hwrite, hready, hresp, irq, tx_v, ooi, seq_en, busy_exp = 1'h0;
    logic [7:0]  haddr, tx_b, rssi = 8'h00;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic [15:0] q;
    logic [7:0]  bytes[$];
    int          num_errors = 0;
    int          checks_done = 0;

    always #2 clk = ~clk;
    always @(posedge clk)
        if (tx_v === 1'h1)
            bytes.push_back(tx_b);

    stca_modem #(.WARM_CYC(WC), .SYM_CYC(SC), .BYTE_CYC(8)) i_stca_modem
    (
        .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .SEQUENCE_ENABLE_PIN(seq_en), .RSSI_LEVEL(rssi), .IRQ(irq), .TX_BYTE(tx_b),
        .TX_BYTE_VALID(tx_v), .OUT_OF_IDLE_INDICATOR(ooi)
    );
    stca_host i_stca_host
    (
        .clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .seq_en(seq_en)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_on(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask : wait_on

    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ stca_pkg::FCS_POLY : c >> 1;
        return c;
    endfunction : crc16

    task automatic t_regs;
        i_stca_host.xfer(stca_pkg::IDX_THRESH, 1'h0, 16'h0000, q);
        check("threshold reset", q, 16'h008d);
        i_stca_host.wr(6'h3f, 16'hffff);
        i_stca_host.xfer(6'h3f, 1'h0, 16'h0000, q);
        check("unmapped", q, 16'h0000);
    endtask : t_regs

    // Three words, two requests
    task automatic t_stream;
        logic [15:0] w[3] = '{16'h1234, 16'hbeef, 16'h00a5};
        logic [15:0] c = 16'h0000;
        int n;
        bytes.delete();
        i_stca_host.arm_stream(7'h08, w[0], 16'h0080, 16'h0200);
        for (int k = 1; k < 3; k++)
        begin
            wait_on(irq, 1'h1, 200, n);
            check("word irq", irq, 1'h1);
            i_stca_host.wr(stca_pkg::IDX_TX_DATA, w[k]);
            wait_on(irq, 1'h0, 4, n);
            check("irq cleared", irq, 1'h0);
        end
        wait_on(irq, 1'h1, 200, n);
        i_stca_host.xfer(stca_pkg::IDX_STATUS, 1'h0, 16'h0000, q);
        check("done status", q & 16'h4044, 16'h4000);
        check("frame size", 16'(bytes.size()), 16'h000e);
        check("delimiter", bytes[4], 8'ha7);
        check("length", bytes[5], 8'h08);
        for (int k = 0; k < 6; k++)
        begin
            check("payload", bytes[6 + k], w[k / 2][8 * (k % 2) +: 8]);
            c = crc16(c, w[k / 2][8 * (k % 2) +: 8]);
        end
        check("fcs", {bytes[13], bytes[12]}, c);
    endtask : t_stream

    // Only the missed deadline may interrupt
    task automatic t_starve;
        int n;
        i_stca_host.arm_stream(7'h06, 16'h5a5a, 16'h0100, 16'h0000);
        wait_on(irq, 1'h1, 200, n);
        i_stca_host.xfer(stca_pkg::IDX_STATUS, 1'h0, 16'h0000, q);
        check("error status", q & 16'h0044, 16'h0044);
        wait_on(ooi, 1'h0, 200, n);
        check("done masked", irq, 1'h0);
        i_stca_host.xfer(stca_pkg::IDX_STATUS, 1'h0, 16'h0000, q);
        check("done status", q & 16'h4004, 16'h4000);
    endtask : t_starve

    task automatic t_assess(input logic [1:0] typ, input logic [7:0] lvl, input logic [15:0] thc);
        logic [8:0] s;
        logic [7:0] res;
        int n;
        s = {1'h0, lvl} + thc[7:1];
        res = s[8] ? 8'hff : s[7:0];
        if (typ == stca_pkg::TYPE_THRESH)
            busy_exp = res <= thc[15:8];
        rssi <= lvl;
        i_stca_host.arm_assess(thc, typ);
        wait_on(irq, 1'h1, 400, n);
        check("measure time", 16'(n >= WC + 8 * SC && n <= WC + 8 * SC + 6), 16'h0001);
        i_stca_host.xfer(stca_pkg::IDX_STATUS, 1'h0, 16'h0000, q);
        check("measure status", q & 16'h0022, {10'h000, 1'h1, 3'h0, busy_exp, 1'h0});
        i_stca_host.xfer(stca_pkg::IDX_RX_POWER, 1'h0, 16'h0000, q);
        check("power", q[15:8], res);
    endtask : t_assess

    task automatic report_and_stop;
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        t_regs();
        t_stream();
        t_starve();
        // Energy runs must leave the busy flag alone
        t_assess(2'h1, 8'h5e, 16'ha48d);
        t_assess(2'h2, 8'h70, 16'ha48d);
        t_assess(2'h1, 8'h5f, 16'ha48d);
        t_assess(2'h2, 8'hf0, 16'hffff);
        report_and_stop();
    end

    initial
    begin
        #40000;
        num_errors++;
        report_and_stop();
    end
endmodule : testbench
